//--- logic/dra_cfg_if.sv
// configuration carried from the register file to the address paths
`timescale 1ns/1ps
interface dra_cfg_if;
  logic [1:0] rot_sel;
  logic [1:0] bpp;
  logic [23:0] start_addr;
  logic [15:0] line_pitch;
  modport src (output rot_sel, output bpp, output start_addr, output line_pitch);
  modport dst (input rot_sel, input bpp, input start_addr, input line_pitch);
endinterface : dra_cfg_if

//--- logic/dra_cpu_xlate.sv
// cpu display-buffer address translation for the 90 and 270 degree modes
`timescale 1ns/1ps
module dra_cpu_xlate (
  input wire logic core_clk,
  input wire logic sys_rst,
  dra_cfg_if.dst cfg,
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic [dra_pkg::ADDR_W-1:0] acc_addr,
  output logic mem_req_q,
  output logic mem_we_q,
  output logic [dra_pkg::ADDR_W-1:0] mem_addr_q
);
  localparam int CW = dra_pkg::COORD_W;

  logic wide;
  logic depth_ok;
  logic [2*CW-1:0] pix;
  logic [CW-1:0] px;
  logic [CW-1:0] py;
  logic [2*CW-1:0] rpix;
  logic [dra_pkg::ADDR_W-1:0] mem_addr_d;

  always_comb begin
    wide = (cfg.bpp == dra_pkg::BPP_16);
    // 4 bpp has no rotated layout; such accesses pass untouched
    depth_ok = wide || (cfg.bpp == dra_pkg::BPP_8);
    pix = wide ? acc_addr[2*CW:1] : acc_addr[2*CW-1:0];
    px = pix[CW-1:0];
    py = pix[2*CW-1:CW];
    rpix = pix;
    mem_addr_d = acc_addr;
    case (cfg.rot_sel)
      dra_pkg::ROT_90: rpix = {px, ~py};
      dra_pkg::ROT_270: rpix = {~px, py};
      default: rpix = pix;
    endcase
    if (depth_ok && cfg.rot_sel[0]) begin
      if (wide) begin
        mem_addr_d = {rpix, acc_addr[0]};
      end else begin
        mem_addr_d = {acc_addr[dra_pkg::ADDR_W-1], rpix};
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= '0;
    end else begin
      mem_req_q <= acc_req;
      mem_we_q <= acc_we;
      mem_addr_q <= mem_addr_d;
    end
  end
endmodule : dra_cpu_xlate

//--- logic/dra_fetch_gen.sv
// refresh fetch word address walker
`timescale 1ns/1ps
module dra_fetch_gen (
  input wire logic core_clk,
  input wire logic sys_rst,
  dra_cfg_if.dst cfg,
  input wire logic frame_start,
  input wire logic line_next,
  input wire logic word_next,
  output logic [dra_pkg::WORD_W-1:0] fetch_addr_q
);
  localparam int WW = dra_pkg::WORD_W;

  logic rev;
  logic [WW-1:0] base_q;
  logic [WW-1:0] start_w;
  logic [WW-1:0] pitch_w;
  logic [WW-1:0] next_base;

  always_comb begin
    rev = (cfg.rot_sel == dra_pkg::ROT_180);
    start_w = cfg.start_addr[WW-1:0];
    pitch_w = {{(WW-16){1'b0}}, cfg.line_pitch};
    // line stride follows the pitch, so start steps scroll or pan
    next_base = rev ? base_q - pitch_w : base_q + pitch_w;
  end

  // frame start beats line and word steps arriving together
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      base_q <= '0;
      fetch_addr_q <= '0;
    end else if (frame_start) begin
      base_q <= start_w;
      fetch_addr_q <= start_w;
    end else if (line_next) begin
      base_q <= next_base;
      fetch_addr_q <= next_base;
    end else if (word_next) begin
      fetch_addr_q <= rev ? fetch_addr_q - 1'b1 : fetch_addr_q + 1'b1;
    end
  end
endmodule : dra_fetch_gen

//--- logic/dra_pkg.sv
// constants shared by the display rotation addressing logic
package dra_pkg;
  localparam int ADDR_W = 21;
  localparam int WORD_W = 20;
  localparam int VIRT_SIDE = 1024;
  localparam int COORD_W = $clog2(VIRT_SIDE);
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h40;
  localparam logic [7:0] IDX_START_LO = 8'h42;
  localparam logic [7:0] IDX_START_MID = 8'h43;
  localparam logic [7:0] IDX_START_HI = 8'h44;
  localparam logic [7:0] IDX_PAN = 8'h45;
  localparam logic [7:0] IDX_PITCH_LO = 8'h46;
  localparam logic [7:0] IDX_PITCH_HI = 8'h47;
  localparam logic [7:0] IDX_STATUS = 8'h48;
  // control register fields
  localparam int CTRL_ROT_LSB = 0;
  localparam int CTRL_BPP_LSB = 2;
  localparam int PAN_W = 4;
  // rotation select encodings
  localparam logic [1:0] ROT_0 = 2'h0;
  localparam logic [1:0] ROT_90 = 2'h1;
  localparam logic [1:0] ROT_180 = 2'h2;
  localparam logic [1:0] ROT_270 = 2'h3;
  // colour depth encodings
  localparam logic [1:0] BPP_4 = 2'h0;
  localparam logic [1:0] BPP_8 = 2'h1;
  localparam logic [1:0] BPP_16 = 2'h2;
  // reset values and bus encodings
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // largest pixel-panning value within one 16-bit word
  function automatic logic [PAN_W-1:0] pan_mask(input logic [1:0] bpp);
    case (bpp)
      BPP_4: pan_mask = 4'h3;
      BPP_8: pan_mask = 4'h1;
      default: pan_mask = 4'h0;
    endcase
  endfunction : pan_mask
endpackage : dra_pkg

//--- logic/dra_top.sv
// display rotation addressing: register slave, cpu translation, refresh walk
`timescale 1ns/1ps
module dra_top (
  input wire logic core_clk,
  input wire logic sys_rst,
  // ahb-lite register slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic [1:0] hresp,
  // cpu display-buffer access
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic [dra_pkg::ADDR_W-1:0] acc_addr,
  output logic mem_req,
  output logic mem_we,
  output logic [dra_pkg::ADDR_W-1:0] mem_addr,
  // refresh fetch path
  input wire logic frame_start,
  input wire logic line_next,
  input wire logic word_next,
  output logic [dra_pkg::WORD_W-1:0] fetch_addr,
  output logic [dra_pkg::PAN_W-1:0] fetch_pan
);
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_RD_WAIT
  } dra_bus_type;

  dra_cfg_if cfg ();

  dra_bus_type bus_q;
  logic wr_pend_q;
  logic [7:0] idx_q;
  logic [7:0] ctrl_q;
  logic [7:0] start_lo_q;
  logic [7:0] start_mid_q;
  logic [7:0] start_hi_q;
  logic [7:0] pitch_lo_q;
  logic [7:0] pitch_hi_q;
  logic [dra_pkg::PAN_W-1:0] pan_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic [1:0] hresp_q;
  logic [dra_pkg::PAN_W-1:0] fetch_pan_q;
  logic [dra_pkg::PAN_W-1:0] fetch_pan_d;
  logic [31:0] rd_mux;
  logic take;
  logic take_idx_ok;
  logic [dra_pkg::WORD_W-1:0] fetch_addr_w;

  // address phase taken for any selected nonseq access; word size and alignment are checked separately
  always_comb begin
    take = hsel && hready && (htrans == dra_pkg::HTRANS_NONSEQ);
    take_idx_ok = (haddr[1:0] == 2'h0) && (hsize == 3'h2);
  end

  // bus phase tracking; reads add one wait so a write just before is seen
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_q <= BUS_IDLE;
      hreadyout_q <= 1'b1;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          if (take && !hwrite) begin
            bus_q <= BUS_RD_WAIT;
            hreadyout_q <= 1'b0;
          end
        end
        BUS_RD_WAIT: begin
          bus_q <= BUS_IDLE;
          hreadyout_q <= 1'b1;
        end
        default: begin
          bus_q <= BUS_IDLE;
          hreadyout_q <= 1'b1;
        end
      endcase
    end
  end

  // captured word index; misaligned or narrow accesses land nowhere
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx_q <= 8'h00;
      wr_pend_q <= 1'b0;
    end else if (take) begin
      idx_q <= take_idx_ok ? haddr[9:2] : 8'h00;
      wr_pend_q <= hwrite && take_idx_ok;
    end else if (hready) begin
      wr_pend_q <= 1'b0;
    end
  end

  // control register: rotation select and colour depth
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= dra_pkg::CTRL_RST;
    end else if (wr_pend_q && idx_q == dra_pkg::IDX_CTRL) begin
      ctrl_q <= {4'h0, hwdata[3:0]};
    end
  end

  // panel start address, three bytes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_lo_q <= dra_pkg::REG8_RST;
      start_mid_q <= dra_pkg::REG8_RST;
      start_hi_q <= dra_pkg::REG8_RST;
    end else if (wr_pend_q) begin
      if (idx_q == dra_pkg::IDX_START_LO) begin
        start_lo_q <= hwdata[7:0];
      end
      if (idx_q == dra_pkg::IDX_START_MID) begin
        start_mid_q <= hwdata[7:0];
      end
      if (idx_q == dra_pkg::IDX_START_HI) begin
        start_hi_q <= hwdata[7:0];
      end
    end
  end

  // panel line pitch, two bytes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pitch_lo_q <= dra_pkg::REG8_RST;
      pitch_hi_q <= dra_pkg::REG8_RST;
    end else if (wr_pend_q) begin
      if (idx_q == dra_pkg::IDX_PITCH_LO) begin
        pitch_lo_q <= hwdata[7:0];
      end
      if (idx_q == dra_pkg::IDX_PITCH_HI) begin
        pitch_hi_q <= hwdata[7:0];
      end
    end
  end

  // pixel panning value
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pan_q <= '0;
    end else if (wr_pend_q && idx_q == dra_pkg::IDX_PAN) begin
      pan_q <= hwdata[dra_pkg::PAN_W-1:0];
    end
  end

  // read-back mux; unmapped indices read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx_q)
      dra_pkg::IDX_CTRL: rd_mux = {24'h00_0000, ctrl_q};
      dra_pkg::IDX_START_LO: rd_mux = {24'h00_0000, start_lo_q};
      dra_pkg::IDX_START_MID: rd_mux = {24'h00_0000, start_mid_q};
      dra_pkg::IDX_START_HI: rd_mux = {24'h00_0000, start_hi_q};
      dra_pkg::IDX_PAN: rd_mux = {28'h000_0000, pan_q};
      dra_pkg::IDX_PITCH_LO: rd_mux = {24'h00_0000, pitch_lo_q};
      dra_pkg::IDX_PITCH_HI: rd_mux = {24'h00_0000, pitch_hi_q};
      dra_pkg::IDX_STATUS: rd_mux = {12'h000, fetch_addr_w};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data loaded in the wait cycle and held until the next read
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (bus_q == BUS_RD_WAIT) begin
      hrdata_q <= rd_mux;
    end
  end

  // every transfer answers okay, including unmapped ones
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hresp_q <= dra_pkg::HRESP_OKAY;
    end else begin
      hresp_q <= dra_pkg::HRESP_OKAY;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;

  // configuration fan-out to both address paths
  assign cfg.rot_sel = ctrl_q[dra_pkg::CTRL_ROT_LSB +: 2];
  assign cfg.bpp = ctrl_q[dra_pkg::CTRL_BPP_LSB +: 2];
  assign cfg.start_addr = {start_hi_q, start_mid_q, start_lo_q};
  assign cfg.line_pitch = {pitch_hi_q, pitch_lo_q};

  // panning sense flips in 180 and 270; the fetch side sees it ready-made
  always_comb begin
    fetch_pan_d = pan_q & dra_pkg::pan_mask(cfg.bpp);
    if (cfg.rot_sel == dra_pkg::ROT_180 || cfg.rot_sel == dra_pkg::ROT_270) begin
      fetch_pan_d = dra_pkg::pan_mask(cfg.bpp) - fetch_pan_d;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_pan_q <= '0;
    end else begin
      fetch_pan_q <= fetch_pan_d;
    end
  end

  assign fetch_pan = fetch_pan_q;

  // cpu display-buffer accesses reach memory through the translated port
  dra_cpu_xlate u_xlate (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .cfg(cfg.dst),
    .acc_req(acc_req),
    .acc_we(acc_we),
    .acc_addr(acc_addr),
    .mem_req_q(mem_req),
    .mem_we_q(mem_we),
    .mem_addr_q(mem_addr)
  );

  dra_fetch_gen u_fetch (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .cfg(cfg.dst),
    .frame_start(frame_start),
    .line_next(line_next),
    .word_next(word_next),
    .fetch_addr_q(fetch_addr_w)
  );

  assign fetch_addr = fetch_addr_w;
endmodule : dra_top

//--- testbench/dra_refresh_model.sv
// refresh pacer standing in for the display fetch side
`timescale 1ns/1ps
module dra_refresh_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic [1:0] kind,
  output logic frame_start,
  output logic line_next,
  output logic word_next
);
  // one pulse per request, one kind at a time
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_start <= 1'b0;
      line_next <= 1'b0;
      word_next <= 1'b0;
    end else begin
      frame_start <= go && kind == 2'h1;
      line_next <= go && kind == 2'h2;
      word_next <= go && kind == 2'h3;
    end
  end
endmodule : dra_refresh_model

//--- testbench/dra_top_monitor.sv
// port checker for the rotation addressing block
`timescale 1ns/1ps
module dra_top_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] hresp,
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic frame_start,
  input wire logic line_next,
  input wire logic word_next,
  input wire logic [19:0] fetch_addr,
  input wire logic [3:0] fetch_pan
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire take = hsel && hready && htrans == dra_pkg::HTRANS_NONSEQ;
  wire pulse = frame_start || line_next || word_next;
  sequence s_rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait; take && !hwrite |=> s_rd_ans; endproperty
  property p_wr_nowait; take && hwrite |=> hreadyout; endproperty
  property p_okay; hresp == dra_pkg::HRESP_OKAY; endproperty
  property p_rd_stand; $past(hreadyout) && hreadyout |-> $stable(hrdata); endproperty
  property p_req_follow; acc_req |=> mem_req && mem_we == $past(acc_we); endproperty
  property p_no_req; !acc_req |=> !mem_req; endproperty
  property p_fetch_hold; !pulse |=> $stable(fetch_addr); endproperty
  property p_word_step;
    word_next && !frame_start && !line_next |=>
      fetch_addr == $past(fetch_addr) + 1'b1 || fetch_addr == $past(fetch_addr) - 1'b1;
  endproperty
  property p_pan_lim; fetch_pan <= 4'h3; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read answer late");
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  a_okay: assert property (p_okay) else $error("response not okay");
  a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
  a_req_follow: assert property (p_req_follow) else $error("access lost");
  a_no_req: assert property (p_no_req) else $error("spurious access");
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch moved");
  a_word_step: assert property (p_word_step) else $error("bad word step");
  a_pan_lim: assert property (p_pan_lim) else $error("pan too large");
endmodule : dra_top_monitor
bind dra_top dra_top_monitor mon_u (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .acc_req(acc_req), .acc_we(acc_we), .mem_req(mem_req),
  .mem_we(mem_we), .frame_start(frame_start), .line_next(line_next),
  .word_next(word_next), .fetch_addr(fetch_addr), .fetch_pan(fetch_pan));

//--- testbench/tb_display_rotation_addressing.sv
// self-checking bench for the rotation addressing block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_display_rotation_addressing;
  typedef struct packed {
    logic [1:0] rot;
    logic [1:0] bpp;
    logic [20:0] a;
    logic [20:0] e;
  } dra_row_type;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic [31:0] hrdata;
  logic acc_req = 1'b0;
  logic acc_we = 1'b0;
  logic [20:0] acc_addr = 21'h0_0000;
  logic mem_req;
  logic mem_we;
  logic [20:0] mem_addr;
  logic go = 1'b0;
  logic [1:0] kind = 2'h0;
  logic fs;
  logic ln;
  logic wn;
  logic [19:0] fetch_addr;
  logic [3:0] fetch_pan;
  logic [31:0] rd;
  int fails = 0;
  int n_compared = 0;
  // 16 bpp pixel x=5 y=3, and 8 bpp pixel x=5 y=3 with bit 20 set
  // single-panel layouts only, no rotated dual-panel buffer
  dra_row_type rows [8] = '{
    '{2'h0, 2'h2, 21'h0_180B, 21'h0_180B}, '{2'h1, 2'h2, 21'h0_180B, 21'h0_2FF9},
    '{2'h2, 2'h2, 21'h0_180B, 21'h0_180B}, '{2'h3, 2'h2, 21'h0_180B, 21'h1F_D007},
    '{2'h1, 2'h1, 21'h10_0C05, 21'h10_17FC}, '{2'h3, 2'h1, 21'h10_0C05, 21'h1F_E803},
    '{2'h2, 2'h1, 21'h10_0C05, 21'h10_0C05}, '{2'h1, 2'h0, 21'h0_180B, 21'h0_180B}};
  dra_top dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .acc_req(acc_req), .acc_we(acc_we),
    .acc_addr(acc_addr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .frame_start(fs), .line_next(ln), .word_next(wn), .fetch_addr(fetch_addr),
    .fetch_pan(fetch_pan));
  dra_refresh_model model_u (.core_clk(core_clk), .sys_rst(sys_rst), .go(go), .kind(kind),
    .frame_start(fs), .line_next(ln), .word_next(wn));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= dra_pkg::HTRANS_NONSEQ;
    haddr <= {2'h0, idx, 2'h0};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    ahb(1'b1, idx, wd);
    repeat (2) @(posedge core_clk);
    #1;
  endtask : wr
  task automatic rchk(input logic [7:0] idx, input logic [31:0] ex);
    ahb(1'b0, idx, 32'h0000_0000);
    `CHK(rd, ex)
  endtask : rchk
  task automatic refr(input logic [1:0] k);
    @(posedge core_clk);
    go <= 1'b1;
    kind <= k;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask : refr
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    // generous: whole run is a few hundred cycles
    #3_000_000;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    `CHK(fetch_addr, 20'h0_0000)
    rchk(dra_pkg::IDX_CTRL, 32'h0000_0000);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(dra_pkg::IDX_CTRL, {28'h000_0000, rows[i].bpp, rows[i].rot});
      @(posedge core_clk);
      acc_req <= 1'b1;
      // alternate reads and writes so the write qualifier is seen both ways
      acc_we <= ~acc_we;
      acc_addr <= rows[i].a;
      @(posedge core_clk);
      acc_req <= 1'b0;
      #1;
      `CHK({mem_req, mem_we, mem_addr}, {1'b1, acc_we, rows[i].e})
    end
    $display("translation rows done");
    // 180 at 8 bpp with bit 0 cleared, as for cursor, ink or crt/tv buffers
    wr(dra_pkg::IDX_CTRL, 32'h0000_0006);
    @(posedge core_clk);
    acc_req <= 1'b1;
    acc_addr <= 21'h10_0C05;
    @(posedge core_clk);
    acc_req <= 1'b0;
    #1;
    `CHK({mem_req, mem_addr}, {1'b1, 21'h10_0C05})
    $display("bit 0 cleared access done");
    wr(dra_pkg::IDX_CTRL, 32'h0000_0000);
    wr(dra_pkg::IDX_START_LO, 32'h0000_0000);
    wr(dra_pkg::IDX_START_MID, 32'h0000_0001);
    wr(dra_pkg::IDX_START_HI, 32'h0000_0000);
    wr(dra_pkg::IDX_PITCH_LO, 32'h0000_0010);
    wr(dra_pkg::IDX_PITCH_HI, 32'h0000_0000);
    rchk(dra_pkg::IDX_START_MID, 32'h0000_0001);
    rchk(dra_pkg::IDX_PITCH_LO, 32'h0000_0010);
    rchk(8'h41, 32'h0000_0000);
    refr(2'h1);
    refr(2'h3);
    `CHK(fetch_addr, 20'h0_0101)
    refr(2'h2);
    `CHK(fetch_addr, 20'h0_0110)
    wr(dra_pkg::IDX_CTRL, 32'h0000_0002);
    refr(2'h1);
    `CHK(fetch_addr, 20'h0_0100)
    refr(2'h3);
    refr(2'h3);
    `CHK(fetch_addr, 20'h0_00FE)
    refr(2'h2);
    `CHK(fetch_addr, 20'h0_00F0)
    rchk(dra_pkg::IDX_STATUS, 32'h0000_00F0);
    $display("refresh walk done");
    wr(dra_pkg::IDX_PAN, 32'h0000_0001);
    `CHK(fetch_pan, 4'h2)
    wr(dra_pkg::IDX_CTRL, 32'h0000_0000);
    `CHK(fetch_pan, 4'h1)
    wr(dra_pkg::IDX_CTRL, 32'h0000_0007);
    `CHK(fetch_pan, 4'h0)
    wr(dra_pkg::IDX_PAN, 32'h0000_0000);
    `CHK(fetch_pan, 4'h1)
    // 270 at 8 bpp: pitch 512, start one line stride later each step
    wr(dra_pkg::IDX_PITCH_LO, 32'h0000_0000);
    wr(dra_pkg::IDX_PITCH_HI, 32'h0000_0002);
    rchk(dra_pkg::IDX_PITCH_HI, 32'h0000_0002);
    wr(dra_pkg::IDX_START_LO, 32'h0000_00FF);
    wr(dra_pkg::IDX_START_MID, 32'h0000_0005);
    refr(2'h1);
    `CHK(fetch_addr, 20'h0_05FF)
    wr(dra_pkg::IDX_START_MID, 32'h0000_0007);
    refr(2'h1);
    `CHK(fetch_addr, 20'h0_07FF)
    // one line stride on, still well inside the 1024 pixel window
    refr(2'h2);
    `CHK(fetch_addr, 20'h0_09FF)
    $display("pan and start done");
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    `CHK({fetch_addr, fetch_pan}, 24'h00_0000)
    rchk(dra_pkg::IDX_CTRL, 32'h0000_0000);
    $display("second reset done");
    end_of_test();
  end
endmodule : tb_display_rotation_addressing
